// ### sscr_map.svh
// Register offsets, field positions, codes and reset values of the sensor link block
`ifndef SSCR_MAP_SVH
`define SSCR_MAP_SVH
// APB byte offsets
`define SSCR_APB_CTRL        8'h00
`define SSCR_APB_ACCEL       8'h04
`define SSCR_APB_STATUS      8'h08
`define SSCR_APB_CFG         8'h0c
// APB control register bits
`define SSCR_CTRL_INIT_DONE  0
`define SSCR_CTRL_FAULT      1
`define SSCR_CTRL_ST_RUN     2
`define SSCR_CTRL_ST_ERR     3
`define SSCR_CTRL_OFFSET     4
`define SSCR_CTRL_CRC        5
`define SSCR_CTRL_RESET      6'h00
// Link register addresses
`define SSCR_ADDR_CTL        5'h00
`define SSCR_ADDR_CFG        5'h01
`define SSCR_ADDR_STATE      5'h02
// Addresses that can be neither read nor written
`define SSCR_BLOCKED_MASK    32'h0f0a_a280
// Configuration register bits
`define SSCR_CFG_OC          7
`define SSCR_CFG_SD          4
`define SSCR_CFG_LOCK        3
`define SSCR_CFG_ARM2        2
`define SSCR_CFG_ARM1        1
// Command bits
`define SSCR_CMD_OC          12
`define SSCR_CMD_BIT3        3
`define SSCR_CMD_SD          2
`define SSCR_CMD_ARM         1
`define SSCR_FRAME_BITS      5'h10
// Response status field
`define SSCR_ST_INIT         2'h0
`define SSCR_ST_NORMAL       2'h1
`define SSCR_ST_SELF         2'h2
`define SSCR_ST_ERR          2'h3
// Error response data codes
`define SSCR_ERR_FRAME       12'h000
`define SSCR_ERR_RBACK       12'h001
`define SSCR_ERR_INV_ACC     12'h002
`define SSCR_ERR_INV_REG     12'h004
`define SSCR_ERR_INTERNAL    12'h008
`define SSCR_ERR_SELF        12'h010
// Response word sent in the first frame after reset
`define SSCR_RESP_RESET      16'hb000
`endif

// ### sscr_pkg.sv
// Types shared by the sensor link block
package sscr_pkg;
    // Received command word
    typedef struct packed {
        logic        hi;
        logic        ax;
        logic        acc;
        logic [12:0] body;
    } sscr_cmd_t;
    // Link pins as sampled
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
        logic miso_rb;
    } sscr_pins_t;
    // Kind of answer queued for the next frame
    typedef enum logic [3:0] {
        RSP_FRAME, RSP_RBACK, RSP_INV_ACC, RSP_INV_REG, RSP_INTERNAL,
        RSP_SELF_ERR, RSP_ACCEL, RSP_WRITE, RSP_READ
    } sscr_rsp_t;
endpackage

// ### sscr_top.sv
// Sensor serial link: command decode, checks, response build and APB access
// How it works
// R01: Acceleration request needs acc bit and bit3
// R02: Select bit one makes request invalid
// R03: Request config bits compared with stored config
// R04: Config mismatch flags invalid, no data
// R05: Every command must have odd parity
// R06: Data only when all flags but readback clear
// R07: Two-bit status field tags acceleration data
// R08: Acc bit zero: read or write by select
// R09: Write carries address and data byte
// R10: Write acknowledged unless errored, or locked and not to control
// R11: Register answers carry byte in low bits
// R12: Write commits at frame end, dropped on framing error
// R13: Read command holds low byte zero
// R14: Eight-level priority picks the error answer
// R15: Framing error answers error, arm unchanged
// R16: Edge, count and parity framing checks
// R17: Format checks on acceleration and read commands
// R18: Output pin read back every bit
// R19: Readback error voids acceleration request
// R20: Readback error still performs register write
// R21: Readback error voids read, keeps status flags
// R22: Readback flag holds until clean status read
// R23: Pulse output off while init or reset
// R24: First frame after reset answers framing error
// R25: Status read clears reset-occurred flag
// R26: Invalid request answered next frame, no fault
// R27: Sixteen bits, MSB first, sample on rise
`timescale 1ns/10ps
`include "sscr_map.svh"
module sscr_top
    import sscr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    input  wire logic        miso_rb,
    output logic             miso_o,
    output logic             miso_oe,
    output logic             arm_out,
    output logic             pulse_en
);
    localparam sscr_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0, miso_rb: 1'b0};
    localparam logic [31:0] BLOCKED  = `SSCR_BLOCKED_MASK; // Addresses with no access

    sscr_pins_t  pin_in;          // Raw pins
    sscr_pins_t  sync1_reg;       // First synchroniser stage
    sscr_pins_t  sync2_reg;       // Second synchroniser stage
    logic        sclk_d_reg;      // Previous clock level
    logic        cs_d_reg;        // Previous select level
    logic        cs_fall;         // Frame start
    logic        cs_rise;         // Frame end
    logic        in_frame;        // Select held low
    logic        sclk_rise;       // Sample edge
    logic        sclk_fall;       // Shift edge
    logic [15:0] rx_reg;          // Command shift register
    logic [15:0] tx_reg;          // Response shift register
    logic [4:0]  cnt_reg;         // Rising edges this frame
    logic        edge_err_reg;    // Clock high at frame start
    logic        rb_err_reg;      // Readback mismatch this frame
    logic [15:0] resp_reg;        // Word for next frame
    sscr_rsp_t   kind_reg;        // Kind of that word
    logic        first_reg;       // No frame ended since reset
    logic [7:0]  regs_reg [32];   // Link register array
    logic        init_flag_reg;   // Init pending
    logic        reset_flag_reg;  // Reset occurred
    logic        fault_flag_reg;  // Internal fault
    logic        rb_flag_reg;     // Readback mismatch
    logic        offset_flag_reg; // Offset monitor error
    logic [5:0]  ctrl_reg;        // APB control bits
    logic [11:0] accel_reg;       // Acceleration sample
    logic        arm_out_reg;     // Arming output
    logic        pulse_en_reg;    // Pulse output enable
    logic [31:0] prdata_reg;      // APB read data
    sscr_cmd_t   cmd;             // Decoded command
    logic [4:0]  addr;            // Register address
    logic [7:0]  cfg;             // Stored configuration
    logic [7:0]  state_byte;      // Status register view
    logic        arm_cfg;         // OR of arm config bits
    logic        fmt_err;         // Format violation
    logic        frame_err;       // Any framing error
    logic        mismatch;        // Config mismatch
    logic        locked;          // Init lock set
    logic        wr_bad;          // Write not allowed
    logic        reg_bad;         // Register access not allowed
    logic [7:0]  wr_val;          // Value a write stores
    logic [7:0]  rd_val;          // Value a read returns
    sscr_rsp_t   kind_next;       // Answer kind chosen now
    logic [14:0] body;            // Response without parity
    logic [1:0]  acc_status;      // Status for valid data
    logic        wr_en;           // Commit a write
    logic        rd_clear;        // Clean status read
    logic        acc_ok;          // Valid acceleration answer

    // Two-stage synchronisers for all link pins
    assign pin_in = '{sclk: sclk, cs_n: cs_n, mosi: mosi, miso_rb: miso_rb};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= PINS_IDLE;
            sync2_reg <= PINS_IDLE;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Edge history of clock and select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_reg <= 1'b0;
            cs_d_reg   <= 1'b1;
        end else begin
            sclk_d_reg <= sync2_reg.sclk;
            cs_d_reg   <= sync2_reg.cs_n;
        end
    end
    assign cs_fall   = cs_d_reg & ~sync2_reg.cs_n;
    assign cs_rise   = ~cs_d_reg & sync2_reg.cs_n;
    assign in_frame  = ~cs_d_reg & ~sync2_reg.cs_n;
    assign sclk_rise = in_frame & ~sclk_d_reg & sync2_reg.sclk;
    assign sclk_fall = in_frame & sclk_d_reg & ~sync2_reg.sclk;

    // Receive shift, MSB first on rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_reg <= 16'h0000;
        end else if (cs_fall) begin
            rx_reg <= 16'h0000;
        end else if (sclk_rise) begin
            rx_reg <= {rx_reg[14:0], sync2_reg.mosi}; // R27
        end
    end

    // Edge count and start-edge check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg      <= 5'h00;
            edge_err_reg <= 1'b0;
        end else if (cs_fall) begin
            cnt_reg      <= 5'h00;
            edge_err_reg <= sync2_reg.sclk; // R16
        end else if (sclk_rise && cnt_reg != 5'h1f) begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    // Transmit shift, loaded at frame start, next bit on falling edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_reg  <= 16'h0000;
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= ~sync2_reg.cs_n;
            if (cs_fall) begin
                tx_reg <= resp_reg;
            end else if (sclk_fall) begin
                tx_reg <= {tx_reg[14:0], 1'b0}; // R27
            end
        end
    end
    assign miso_o = tx_reg[15];

    // Readback compare of the driven bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_err_reg <= 1'b0;
        end else if (cs_fall) begin
            rb_err_reg <= 1'b0;
        end else if (sclk_rise && sync2_reg.miso_rb != tx_reg[15]) begin
            rb_err_reg <= 1'b1; // R18
        end
    end

    // Command decode and checks
    assign cmd        = rx_reg;
    assign addr       = cmd.body[12:8]; // R09
    assign cfg        = regs_reg[`SSCR_ADDR_CFG];
    assign locked     = cfg[`SSCR_CFG_LOCK];
    assign arm_cfg    = cfg[`SSCR_CFG_ARM2] | cfg[`SSCR_CFG_ARM1]; // R03
    assign state_byte = {init_flag_reg, reset_flag_reg, fault_flag_reg,
                         rb_flag_reg, offset_flag_reg, 3'h0};
    // R17 R13
    assign fmt_err = cmd.acc ? (cmd.hi | (|cmd.body[11:4]) | ~cmd.body[`SSCR_CMD_BIT3])
                             : (~cmd.ax & (|cmd.body[7:0]));
    // R16 R05
    assign frame_err = edge_err_reg | sync2_reg.sclk | (cnt_reg != `SSCR_FRAME_BITS)
                     | ~(^rx_reg) | fmt_err;
    // R03 R04
    assign mismatch = (cmd.body[`SSCR_CMD_OC] != cfg[`SSCR_CFG_OC])
                    | (cmd.body[`SSCR_CMD_SD] != cfg[`SSCR_CFG_SD])
                    | (cmd.body[`SSCR_CMD_ARM] != arm_cfg);
    // R10
    assign wr_bad  = BLOCKED[addr] | (addr == `SSCR_ADDR_STATE)
                   | (locked & (addr != `SSCR_ADDR_CTL));
    assign reg_bad = cmd.ax ? wr_bad : BLOCKED[addr]; // R08
    // R10
    assign wr_val  = locked ? {cmd.body[7:6], regs_reg[addr][5:0]} : cmd.body[7:0];
    assign rd_val  = (addr == `SSCR_ADDR_STATE) ? state_byte : regs_reg[addr];
    // R07
    assign acc_status = ctrl_reg[`SSCR_CTRL_ST_RUN] ? `SSCR_ST_SELF
                      : (locked ? `SSCR_ST_NORMAL : `SSCR_ST_INIT);

    // Answer selection in priority order
    always_comb begin
        if (frame_err) begin
            kind_next = RSP_FRAME; // R14 R15
        end else if (rb_err_reg) begin
            kind_next = RSP_RBACK; // R19 R20 R21
        end else if (cmd.acc) begin // R01
            if (cmd.ax | mismatch) begin
                kind_next = RSP_INV_ACC; // R02 R04 R26
            end else if (init_flag_reg) begin
                kind_next = RSP_INTERNAL; // R06
            end else if (reset_flag_reg) begin
                kind_next = RSP_INV_ACC;
            end else if (ctrl_reg[`SSCR_CTRL_CRC]) begin
                kind_next = RSP_INTERNAL;
            end else if (ctrl_reg[`SSCR_CTRL_ST_ERR]) begin
                kind_next = RSP_SELF_ERR;
            end else if (offset_flag_reg | fault_flag_reg) begin
                kind_next = RSP_INTERNAL;
            end else begin
                kind_next = RSP_ACCEL;
            end
        end else if (reg_bad) begin
            kind_next = RSP_INV_REG;
        end else begin
            kind_next = cmd.ax ? RSP_WRITE : RSP_READ; // R08
        end
    end

    // Response word contents
    always_comb begin
        unique case (kind_next)
            RSP_FRAME:    body = {1'b0, `SSCR_ST_ERR, `SSCR_ERR_FRAME};
            RSP_RBACK:    body = {1'b0, `SSCR_ST_ERR, `SSCR_ERR_RBACK};
            RSP_INV_ACC:  body = {cmd.ax, `SSCR_ST_ERR, `SSCR_ERR_INV_ACC};
            RSP_INV_REG:  body = {1'b0, `SSCR_ST_ERR, `SSCR_ERR_INV_REG};
            RSP_INTERNAL: body = {cmd.ax, `SSCR_ST_ERR, `SSCR_ERR_INTERNAL};
            RSP_SELF_ERR: body = {cmd.ax, `SSCR_ST_ERR, `SSCR_ERR_SELF};
            RSP_ACCEL:    body = {cmd.ax, acc_status, accel_reg}; // R07
            RSP_WRITE:    body = {1'b1, 6'h00, wr_val}; // R11
            RSP_READ:     body = {1'b0, 6'h00, rd_val}; // R11
            default:      body = {1'b0, `SSCR_ST_ERR, `SSCR_ERR_FRAME};
        endcase
    end

    assign wr_en    = cs_rise & ~frame_err & ~cmd.acc & cmd.ax & ~wr_bad; // R12 R20
    assign rd_clear = cs_rise & (kind_next == RSP_READ) & (addr == `SSCR_ADDR_STATE); // R21
    assign acc_ok   = cs_rise & (kind_next == RSP_ACCEL);

    // Latch the answer at frame end, odd parity in the top bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_reg  <= `SSCR_RESP_RESET; // R24
            kind_reg  <= RSP_FRAME;
            first_reg <= 1'b1;
        end else if (cs_rise) begin
            resp_reg  <= {~(^body), body};
            kind_reg  <= kind_next;
            first_reg <= 1'b0;
        end
    end

    // Link register array, written only after a frame with no framing error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 32; i++) begin
                regs_reg[i] <= 8'h00;
            end
        end else if (wr_en) begin
            regs_reg[addr] <= wr_val; // R12
        end
    end

    // Init pending clears once the core reports start-up done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_flag_reg <= 1'b1;
        end else if (ctrl_reg[`SSCR_CTRL_INIT_DONE]) begin
            init_flag_reg <= 1'b0;
        end
    end

    // Sticky status flags; a new event wins over a clearing read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_flag_reg  <= 1'b1;
            fault_flag_reg  <= 1'b0;
            rb_flag_reg     <= 1'b0;
            offset_flag_reg <= 1'b0;
        end else begin
            reset_flag_reg  <= reset_flag_reg & ~rd_clear; // R25
            fault_flag_reg  <= ctrl_reg[`SSCR_CTRL_FAULT] | ctrl_reg[`SSCR_CTRL_ST_ERR]
                             | ctrl_reg[`SSCR_CTRL_CRC] | (fault_flag_reg & ~rd_clear);
            rb_flag_reg     <= (sclk_rise & (sync2_reg.miso_rb != tx_reg[15]))
                             | (rb_flag_reg & ~rd_clear); // R18 R22
            offset_flag_reg <= ctrl_reg[`SSCR_CTRL_OFFSET] | (offset_flag_reg & ~rd_clear);
        end
    end

    // Arming follows config only on a valid acceleration answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_out_reg  <= 1'b0;
            pulse_en_reg <= 1'b0;
        end else begin
            if (acc_ok) begin
                arm_out_reg <= arm_cfg; // R15 R19 R26
            end
            pulse_en_reg <= ~(init_flag_reg | reset_flag_reg); // R23
        end
    end
    assign arm_out  = arm_out_reg;
    assign pulse_en = pulse_en_reg;

    // APB writes to control and sample registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= `SSCR_CTRL_RESET;
            accel_reg <= 12'h000;
        end else if (psel && penable && pwrite) begin
            if (paddr == `SSCR_APB_CTRL) begin
                ctrl_reg <= pwdata[5:0];
            end
            if (paddr == `SSCR_APB_ACCEL) begin
                accel_reg <= pwdata[11:0];
            end
        end
    end

    // APB read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                `SSCR_APB_CTRL:   prdata_reg <= {26'h0, ctrl_reg};
                `SSCR_APB_ACCEL:  prdata_reg <= {20'h0, accel_reg};
                `SSCR_APB_STATUS: prdata_reg <= {22'h0, pulse_en_reg, arm_out_reg, state_byte};
                `SSCR_APB_CFG:    prdata_reg <= {24'h0, cfg};
                default:          prdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (paddr != `SSCR_APB_CTRL) & (paddr != `SSCR_APB_ACCEL)
                   & (paddr != `SSCR_APB_STATUS) & (paddr != `SSCR_APB_CFG);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_frame_end_bad;
        cs_rise && frame_err;
    endsequence
    sequence s_bad_count;
        cs_rise && (cnt_reg != `SSCR_FRAME_BITS);
    endsequence

    chk_first_frame_err: assert property (first_reg |-> resp_reg == `SSCR_RESP_RESET) // R24
        else $error("first answer after reset is not the framing error");
    chk_count_frames: assert property (s_bad_count |=> kind_reg == RSP_FRAME) // R16
        else $error("wrong edge count not answered as framing error");
    chk_parity_frame: assert property (cs_rise && !(^rx_reg) |=> kind_reg == RSP_FRAME) // R05
        else $error("even parity not answered as framing error");
    chk_write_dropped: assert property (s_frame_end_bad |-> !wr_en) // R12
        else $error("write committed in a bad frame");
    chk_arm_hold_err: assert property (s_frame_end_bad |=> $stable(arm_out_reg)) // R15
        else $error("arming output moved on framing error");
    chk_rb_flag_set: assert property (sclk_rise && sync2_reg.miso_rb != tx_reg[15] // R18
        |=> rb_flag_reg)
        else $error("readback mismatch not flagged");
    chk_rb_flag_hold: assert property (rb_flag_reg && !rd_clear |=> rb_flag_reg) // R22
        else $error("readback flag cleared without status read");
    chk_pulse_off: assert property (init_flag_reg || reset_flag_reg |=> !pulse_en) // R23
        else $error("pulse output enabled during init or reset");
    chk_rb_answer: assert property (cs_rise && !frame_err && rb_err_reg // R19
        |=> kind_reg == RSP_RBACK ##1 !first_reg)
        else $error("readback frame not answered with readback error");
    chk_resp_parity: assert property (!first_reg |-> ^resp_reg) // R05
        else $error("response word has even parity");
endmodule

// ### sscr_host.sv
// Host-side link master model that drives frames into the sensor block
`timescale 1ns/10ps
module sscr_host (
    input  wire logic pclk,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    output logic      miso_rb,
    input  wire logic miso_o,
    input  wire logic miso_oe
);
    logic corrupt = 1'b0; // Flips the readback to fake a pin fault
    logic last    = 1'b0; // Last level driven on the pin
    logic pin;            // Resolved level of the output pin
    // A released pin shows the inverse of its last driven level
    assign pin     = miso_oe ? miso_o : ~last;
    assign miso_rb = pin ^ corrupt;
    // Remember the level the block drove
    always_ff @(posedge pclk) begin
        if (miso_oe) begin
            last <= miso_o;
        end
    end
    // Idle link: clock low, select high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Wait a number of system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One frame: MSB first, clock idles low, 400 ns link period
    task automatic frame(input logic [15:0] cmd, input int nbits, output logic [15:0] rsp);
        rsp = 16'h0000;
        tick(1);
        cs_n <= 1'b0;
        tick(4);
        for (int i = 0; i < nbits; i++) begin
            mosi <= cmd[15-i];
            tick(4);
            rsp[15-i] = pin;
            sclk <= 1'b1;
            tick(4);
            sclk <= 1'b0;
        end
        tick(4);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        tick(8);
    endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the sensor link block
`timescale 1ns/10ps
`include "sscr_map.svh"
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;  // APB address
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic        pready, pslverr, e, sclk, cs_n, mosi, miso_rb, miso_o, miso_oe;
    logic        arm_out, pulse_en, arm_keep;
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    // 20 MHz system clock
    always #25 pclk = ~pclk;
    sscr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sclk, .cs_n, .mosi, .miso_rb, .miso_o, .miso_oe, .arm_out,
        .pulse_en);
    sscr_host host (.pclk, .sclk, .cs_n, .mosi, .miso_rb, .miso_o, .miso_oe);
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // Compare seen against expected
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", name, exp, got);
        end
    endtask
    // One APB transfer, waiting for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Answer word with odd parity on top
    function automatic logic [15:0] rsp(logic ax, logic [1:0] st, logic [11:0] v);
        return {~^{ax, st, v}, ax, st, v};
    endfunction
    // Acceleration request with odd parity in bit 0
    function automatic logic [15:0] acc(logic oc, logic sd, logic arm, logic ax);
        logic [14:0] w;
        w = {1'b0, ax, 1'b1, oc, 8'h00, 1'b1, sd, arm};
        return {w, ~^w};
    endfunction
    // Register access with odd parity in bit 15
    function automatic logic [15:0] rcmd(logic ax, logic [4:0] a, logic [7:0] v);
        logic [14:0] w;
        w = {ax, 1'b0, a, v};
        return {~^w, w};
    endfunction
    // Run one frame and check the answer to the previous one
    task automatic x(input logic [15:0] c, input logic [15:0] ex,
                     input logic [15:0] m = 16'hffff, input int nb = 16);
        logic [15:0] r;
        host.frame(c, nb, r);
        chk("link answer", r & m, ex);
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("pulse_en", pulse_en, 1'b0);
        apb(1'b0, `SSCR_APB_STATUS, 32'h0, d, e);
        chk("init and reset flags", d[7:6], 2'h3);
        apb(1'b0, 8'h10, 32'h0, d, e);
        chk("unmapped slverr", e, 1'b1);
        apb(1'b1, `SSCR_APB_CTRL, 32'h1, d, e);
        apb(1'b1, `SSCR_APB_ACCEL, 32'h5a3, d, e);
        x(rcmd(1'b1, `SSCR_ADDR_CFG, 8'h92), 16'hb000);
        x(rcmd(1'b0, `SSCR_ADDR_STATE, 8'h00), rsp(1'b1, 2'h0, 12'h092));
        apb(1'b0, `SSCR_APB_CFG, 32'h0, d, e);
        chk("cfg committed", d[7:0], 8'h92);
        apb(1'b0, `SSCR_APB_STATUS, 32'h0, d, e);
        chk("flags cleared", d[7:6], 2'h0);
        chk("pulse_en on", pulse_en, 1'b1);
        x(acc(1'b1, 1'b1, 1'b1, 1'b0), rsp(1'b0, 2'h0, 12'h040));
        x(acc(1'b0, 1'b1, 1'b1, 1'b0), rsp(1'b0, `SSCR_ST_INIT, 12'h5a3));
        x(acc(1'b1, 1'b1, 1'b1, 1'b1), rsp(1'b0, `SSCR_ST_ERR, 12'h002));
        arm_keep = arm_out;
        x(rcmd(1'b1, `SSCR_ADDR_CFG, 8'h9a) ^ 16'h1, rsp(1'b1, 2'h3, 12'h002));
        x(rcmd(1'b0, `SSCR_ADDR_CFG, 8'h01), 16'hb000);
        x(acc(1'b1, 1'b1, 1'b1, 1'b0), 16'hb000, 16'hffff, 15);
        host.corrupt <= 1'b1;
        x(acc(1'b1, 1'b1, 1'b1, 1'b1), 16'hb000);
        host.corrupt <= 1'b0;
        chk("arm held", arm_out, arm_keep);
        apb(1'b0, `SSCR_APB_STATUS, 32'h0, d, e);
        chk("readback flag", d[4], 1'b1);
        apb(1'b0, `SSCR_APB_CFG, 32'h0, d, e);
        chk("cfg kept", d[7:0], 8'h92);
        x(rcmd(1'b0, `SSCR_ADDR_STATE, 8'h00), rsp(1'b0, 2'h3, 12'h001));
        apb(1'b0, `SSCR_APB_STATUS, 32'h0, d, e);
        chk("readback cleared", d[4], 1'b0);
        host.corrupt <= 1'b1;
        x(rcmd(1'b1, `SSCR_ADDR_CFG, 8'h9a), rsp(1'b0, 2'h0, 12'h010));
        host.corrupt <= 1'b0;
        x(acc(1'b1, 1'b1, 1'b1, 1'b0), rsp(1'b0, 2'h3, 12'h001));
        apb(1'b0, `SSCR_APB_CFG, 32'h0, d, e);
        chk("cfg written", d[7:0], 8'h9a);
        apb(1'b1, `SSCR_APB_CTRL, 32'h5, d, e);
        x(acc(1'b1, 1'b1, 1'b1, 1'b0), rsp(1'b0, `SSCR_ST_NORMAL, 12'h5a3));
        x(rcmd(1'b1, `SSCR_ADDR_CFG, 8'h92), rsp(1'b0, `SSCR_ST_SELF, 12'h5a3));
        x(acc(1'b1, 1'b1, 1'b1, 1'b0), rsp(1'b0, 2'h3, 12'h004));
        tally_and_finish();
    end
endmodule
